// ---- fpci_top.v ----
// event and interrupt flag logic of the fast pulse counter.
// assumes the counter datapath drives the running count and an overflow
// pulse, and the controller pulses done at the end of each subroutine.
`timescale 1ns/1ps
`include "fpci_map.vh"

module fpci_top (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [7:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdata_r,
    // counter datapath
    input wire signed [31:0] runningCount,
    input wire [2:0] counterMode,
    input wire overflowEvent,
    // controller
    input wire executingMode,
    input wire subDone,
    output wire subStart,
    output reg [1:0] subSource_r,
    output wire interruptExecuting,
    // retained mask store
    input wire [2:0] retainedMasks,
    output wire [2:0] maskShadow
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function bidirMode;
        input [2:0] m;
        begin
            bidirMode = (m >= `FPCI_MODE_BIDIR);
        end
    endfunction

    // a status bit keeps its value unless software writes a zero to it
    function keepOnWrite;
        input wr;
        input [31:0] d;
        input integer pos;
        begin
            keepOnWrite = !(wr && !d[pos]);
        end
    endfunction

    function moreThanOne;
        input [3:0] v;
        begin
            moreThanOne = (v[0] & v[1]) | (v[0] & v[2]) | (v[0] & v[3]) |
                (v[1] & v[2]) | (v[1] & v[3]) | (v[2] & v[3]);
        end
    endfunction

    // a cause flag: set wins, then any clear source or a software zero
    function causeNext;
        input setIt;
        input cur;
        input clrAny;
        input wr;
        input [31:0] d;
        input integer pos;
        begin
            causeNext = setIt || (cur && !clrAny && keepOnWrite(wr, d, pos));
        end
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg userEnable_r;
    reg lowMask_r;
    reg highMask_r;
    reg underMask_r;
    reg overflowMask_r;
    reg restorePend_r;
    reg signed [31:0] lowPreset_r;
    reg signed [31:0] highPreset_r;
    reg signed [31:0] underLimit_r;
    reg lowReached_r;
    reg highReached_r;
    reg highLevel_r;
    reg signed [31:0] prevCount_r;
    reg underflowFlag_r;
    reg lostFlag_r;
    reg lowCause_r;
    reg highCause_r;
    reg underCause_r;
    reg execPrev_r;

    wire ctrlWr;
    wire statWr;
    wire bidir;
    wire lowLevel;
    wire highLevel;
    wire lowEvent;
    wire highEvent;
    wire underEvent;
    wire [3:0] req;
    wire pushValid;
    reg [1:0] pushSrc;
    wire headValid;
    wire [1:0] headSrc;
    wire pendingAny;
    wire startPulse;
    wire queueLost;
    wire lostSet;
    wire runEntry;
    wire startLow;
    wire startHigh;
    wire startUnder;
    wire startOther;
    wire causeClr;
    reg [31:0] ctrlWord;
    reg [31:0] statWord;

    assign ctrlWr = regWr && (regAddr == `FPCI_OFS_CTRL);
    assign statWr = regWr && (regAddr == `FPCI_OFS_STAT);
    assign bidir = bidirMode(counterMode);

    // ----------------------------------------
    // control register and retained masks
    // ----------------------------------------
    // masks come back from the retained store the cycle after reset,
    // since an async reset may only load constants
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            userEnable_r <= 1'b0;
            lowMask_r <= 1'b0;
            highMask_r <= 1'b0;
            underMask_r <= 1'b0;
            overflowMask_r <= 1'b0;
            restorePend_r <= 1'b1;
        end else begin
            restorePend_r <= 1'b0;
            // R07 restore after power up
            if (restorePend_r) begin
                lowMask_r <= retainedMasks[0];
                highMask_r <= retainedMasks[1];
                underMask_r <= retainedMasks[2];
            end else if (ctrlWr) begin
                // R07 software only
                lowMask_r <= regWdata[`FPCI_CTL_LOWM];
                highMask_r <= regWdata[`FPCI_CTL_HIGHM];
                underMask_r <= regWdata[`FPCI_CTL_UNDM];
            end
            if (ctrlWr) begin
                userEnable_r <= regWdata[`FPCI_CTL_UIE];
                overflowMask_r <= regWdata[`FPCI_CTL_OVFM];
            end
        end
    end

    assign maskShadow = {underMask_r, highMask_r, lowMask_r};

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lowPreset_r <= `FPCI_RST_PRESET;
            highPreset_r <= `FPCI_RST_PRESET;
            underLimit_r <= `FPCI_RST_PRESET;
        end else if (regWr) begin
            if (regAddr == `FPCI_OFS_LOWP) begin
                lowPreset_r <= regWdata;
            end
            if (regAddr == `FPCI_OFS_HIGHP) begin
                highPreset_r <= regWdata;
            end
            if (regAddr == `FPCI_OFS_UNDL) begin
                underLimit_r <= regWdata;
            end
        end
    end

    // ----------------------------------------
    // compare and event detection
    // ----------------------------------------
    assign lowLevel = bidir && (runningCount <= lowPreset_r);
    assign highLevel = (runningCount >= highPreset_r);
    // events are edges of the levels, so a count parked at a preset
    // requests the subroutine once, not every cycle
    assign lowEvent = executingMode && lowLevel && !lowReached_r;
    assign highEvent = executingMode && highLevel && !highLevel_r;
    // R14 downward pass
    assign underEvent = executingMode && (prevCount_r >= underLimit_r) &&
        (runningCount < underLimit_r);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lowReached_r <= 1'b0;
            highReached_r <= 1'b0;
            highLevel_r <= 1'b0;
            prevCount_r <= `FPCI_RST_PRESET;
        end else if (executingMode) begin
            // R10 low reached level
            lowReached_r <= lowLevel;
            // R13 high reached level
            highReached_r <= bidir && highLevel;
            highLevel_r <= highLevel;
            prevCount_r <= runningCount;
        end
    end

    // ----------------------------------------
    // request gating
    // ----------------------------------------
    // R18 user enable gate
    // R06 low mask gate
    assign req[0] = userEnable_r && bidir && lowMask_r && lowEvent;
    // R11 high mask gate
    assign req[1] = userEnable_r && highMask_r && highEvent;
    // R16 underflow mask gate
    assign req[2] = userEnable_r && bidir && underMask_r && underEvent;
    // R19 overflow mask gate
    assign req[3] = userEnable_r && overflowMask_r && overflowEvent;
    assign pushValid = |req;

    // only one request enters per cycle; the rest of a tie count as lost
    always @* begin
        pushSrc = `FPCI_SRC_OVF;
        if (req[0]) begin
            pushSrc = `FPCI_SRC_LOW;
        end else if (req[1]) begin
            pushSrc = `FPCI_SRC_HIGH;
        end else if (req[2]) begin
            pushSrc = `FPCI_SRC_UND;
        end
    end

    // ----------------------------------------
    // subroutine queue
    // ----------------------------------------
    fpci_queue uQueue (
        .clk(clk),
        .rst(rst),
        .pushValid(pushValid),
        .pushSrc(pushSrc),
        .popDone(subDone),
        .headValid(headValid),
        .headSrc(headSrc),
        .pendingAny(pendingAny),
        .startPulse_r(startPulse),
        .lostPulse(queueLost)
    );

    // ----------------------------------------
    // controller outputs
    // ----------------------------------------
    // R01 set on start
    // R02 clear on done
    assign interruptExecuting = headValid;
    assign subStart = startPulse;

    // the head slot is already a flip-flop; registering it again would
    // let the start pulse name the previous source for one cycle
    always @* begin
        subSource_r = headSrc;
    end

    // ----------------------------------------
    // sticky flags
    // ----------------------------------------
    assign lostSet = queueLost || moreThanOne(req);
    assign runEntry = executingMode && !execPrev_r;
    assign startLow = startPulse && (headSrc == `FPCI_SRC_LOW);
    assign startHigh = startPulse && (headSrc == `FPCI_SRC_HIGH);
    assign startUnder = startPulse && (headSrc == `FPCI_SRC_UND);
    assign startOther = startPulse;
    assign causeClr = runEntry || startOther;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lostFlag_r <= 1'b0;
            underflowFlag_r <= 1'b0;
            lowCause_r <= 1'b0;
            highCause_r <= 1'b0;
            underCause_r <= 1'b0;
            execPrev_r <= 1'b0;
        end else begin
            execPrev_r <= executingMode;
            // R05 hardware set wins
            lostFlag_r <= lostSet ||
                (lostFlag_r && keepOnWrite(statWr, regWdata, `FPCI_ST_LOST));
            // R15 flag only, no fault
            underflowFlag_r <= underEvent ||
                (underflowFlag_r && keepOnWrite(statWr, regWdata, `FPCI_ST_UNDF));
            // R09 clear sources
            // R08 low cause
            lowCause_r <= causeNext(startLow, lowCause_r, causeClr,
                statWr, regWdata, `FPCI_ST_LOWC);
            // R12 high cause
            highCause_r <= causeNext(startHigh, highCause_r, causeClr,
                statWr, regWdata, `FPCI_ST_HIGHC);
            // R17 underflow cause
            underCause_r <= causeNext(startUnder, underCause_r, causeClr,
                statWr, regWdata, `FPCI_ST_UNDC);
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // fields are placed by their map positions, so moving a bit is a
    // one-line change in the header
    always @* begin
        ctrlWord = `FPCI_RST_WORD;
        ctrlWord[`FPCI_CTL_UIE] = userEnable_r;
        ctrlWord[`FPCI_CTL_LOWM] = lowMask_r;
        ctrlWord[`FPCI_CTL_HIGHM] = highMask_r;
        ctrlWord[`FPCI_CTL_UNDM] = underMask_r;
        ctrlWord[`FPCI_CTL_OVFM] = overflowMask_r;
    end

    always @* begin
        statWord = `FPCI_RST_WORD;
        statWord[`FPCI_ST_EXEC] = headValid;
        statWord[`FPCI_ST_PEND] = pendingAny;
        statWord[`FPCI_ST_LOST] = lostFlag_r;
        statWord[`FPCI_ST_LOWC] = lowCause_r;
        statWord[`FPCI_ST_LOWR] = lowReached_r;
        statWord[`FPCI_ST_HIGHC] = highCause_r;
        statWord[`FPCI_ST_HIGHR] = highReached_r;
        statWord[`FPCI_ST_UNDF] = underflowFlag_r;
        statWord[`FPCI_ST_UNDC] = underCause_r;
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata_r <= `FPCI_RST_WORD;
        end else if (regRd) begin
            case (regAddr)
                `FPCI_OFS_CTRL: regRdata_r <= ctrlWord;
                `FPCI_OFS_STAT: regRdata_r <= statWord;
                `FPCI_OFS_LOWP: regRdata_r <= lowPreset_r;
                `FPCI_OFS_HIGHP: regRdata_r <= highPreset_r;
                `FPCI_OFS_UNDL: regRdata_r <= underLimit_r;
                default: regRdata_r <= `FPCI_RST_WORD;
            endcase
        end else begin
            regRdata_r <= `FPCI_RST_WORD;
        end
    end

endmodule

// ---- fpci_map.vh ----
// register offsets, field positions, reset values and source codes
// of the pulse counter event and interrupt flag block.
// assumes a byte-addressed register port with 32-bit words.
//
// Notes on behaviour
// R01: executing flag goes to 1 when a counter subroutine starts for any source.
// R02: executing flag returns to 0 once the controller finishes the subroutine.
// R03: read-only pending flag is high while a request waits behind the active one.
// R04: one active plus two pending requests; a further one is dropped and flagged lost.
// R05: only hardware sets the lost flag; only software clears it.
// R06: modes 2 to 7, low mask 0 blocks the low preset subroutine.
// R07: the three masks change only by software and survive a power cycle.
// R08: modes 2 to 7, low cause flag set when low preset triggers the subroutine.
// R09: cause flags clear by software, another source starting, or entering run.
// R10: modes 2 to 7, low reached follows count at or below low preset.
// R11: any mode, high mask 0 blocks the high preset subroutine.
// R12: any mode, high cause flag set when high preset triggers the subroutine.
// R13: modes 2 to 7, high reached follows count at or above high preset.
// R14: underflow flag set when count passes down through the limit; software clears.
// R15: underflow only sets its flag and may request; no fault is raised.
// R16: modes 2 to 7, underflow mask 0 blocks the underflow subroutine.
// R17: modes 2 to 7, underflow cause flag set when underflow triggers the subroutine.
// R18: no subroutine runs for any source unless user interrupt enable is 1.
// R19: overflow mask 0 blocks the overflow subroutine.
// R20: pending requests are served oldest first as each subroutine completes.

`ifndef FPCI_MAP_VH
`define FPCI_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define FPCI_OFS_CTRL 8'h00
`define FPCI_OFS_STAT 8'h04
`define FPCI_OFS_LOWP 8'h08
`define FPCI_OFS_HIGHP 8'h0C
`define FPCI_OFS_UNDL 8'h10

// ----------------------------------------
// control fields
// ----------------------------------------
`define FPCI_CTL_UIE 0
`define FPCI_CTL_LOWM 1
`define FPCI_CTL_HIGHM 2
`define FPCI_CTL_UNDM 3
`define FPCI_CTL_OVFM 4

// ----------------------------------------
// status fields
// ----------------------------------------
`define FPCI_ST_EXEC 0
`define FPCI_ST_PEND 1
`define FPCI_ST_LOST 2
`define FPCI_ST_LOWC 3
`define FPCI_ST_LOWR 4
`define FPCI_ST_HIGHC 5
`define FPCI_ST_HIGHR 6
`define FPCI_ST_UNDF 7
`define FPCI_ST_UNDC 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define FPCI_RST_PRESET 32'h0000_0000
`define FPCI_RST_WORD 32'h0000_0000

// ----------------------------------------
// request sources and queue size
// ----------------------------------------
`define FPCI_SRC_LOW 2'h0
`define FPCI_SRC_HIGH 2'h1
`define FPCI_SRC_UND 2'h2
`define FPCI_SRC_OVF 2'h3
`define FPCI_QCNT_FULL 2'h3
`define FPCI_MODE_BIDIR 3'h2

`endif

// ---- fpci_queue.v ----
// request queue: one active subroutine request plus two waiting ones.
// assumes the done pulse only arrives while a request is active.
`timescale 1ns/1ps
`include "fpci_map.vh"

module fpci_queue (
    // clock and reset
    input wire clk,
    input wire rst,
    // new request
    input wire pushValid,
    input wire [1:0] pushSrc,
    // subroutine finished
    input wire popDone,
    // state
    output wire headValid,
    output wire [1:0] headSrc,
    output wire pendingAny,
    output reg startPulse_r,
    output wire lostPulse
);

    reg [1:0] slot0_r;
    reg [1:0] slot1_r;
    reg [1:0] slot2_r;
    reg [1:0] cnt_r;
    wire pop;
    wire full;
    wire accept;
    wire [1:0] base;
    wire [1:0] cntNxt;

    assign pop = popDone && (cnt_r != 2'h0);
    assign full = (cnt_r == `FPCI_QCNT_FULL);
    // a slot freed in the same cycle still takes the new request
    // R04 drop when full
    assign accept = pushValid && (!full || pop);
    assign lostPulse = pushValid && full && !pop;
    assign base = cnt_r - {1'b0, pop};
    assign cntNxt = base + {1'b0, accept};
    // R01 active entry
    assign headValid = (cnt_r != 2'h0);
    assign headSrc = slot0_r;
    // R03 waiting entries
    assign pendingAny = (cnt_r > 2'h1);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            slot0_r <= 2'h0;
            slot1_r <= 2'h0;
            slot2_r <= 2'h0;
            cnt_r <= 2'h0;
            startPulse_r <= 1'b0;
        end else begin
            // R20 oldest moves up
            if (pop) begin
                slot0_r <= slot1_r;
                slot1_r <= slot2_r;
            end
            if (accept) begin
                case (base)
                    2'h0: slot0_r <= pushSrc;
                    2'h1: slot1_r <= pushSrc;
                    default: slot2_r <= pushSrc;
                endcase
            end
            cnt_r <= cntNxt;
            // head starts when it changes to a live entry
            startPulse_r <= (cntNxt != 2'h0) && ((cnt_r == 2'h0) || pop);
        end
    end

endmodule

// ---- fpci_top_monitor.sv ----
// checker for the counter event and interrupt flag block
// assumes it is bound to fpci_top and sees only its ports
`timescale 1ns/1ps

module fpci_top_monitor (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [7:0] regAddr,
    input wire regWr,
    // counter and controller
    input wire [2:0] counterMode,
    input wire subDone,
    input wire subStart,
    input wire [1:0] subSource_r,
    input wire interruptExecuting,
    input wire [2:0] maskShadow
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // start and finish of a subroutine
    // ----------------------------------------
    exec_on_start_a: assert property ($rose(interruptExecuting) |-> subStart)
        else $error("executing rose without a start pulse");
    start_exec_a: assert property (subStart |-> interruptExecuting)
        else $error("start pulse without executing flag");
    done_release_a: assert property (subDone && interruptExecuting |=> !interruptExecuting || subStart)
        else $error("executing held after done with nothing pending");
    // the head only moves on a done, so a waiting request never steals it
    head_hold_a: assert property (interruptExecuting && !subDone |=> !subStart && $stable(subSource_r))
        else $error("head request changed without a done");

    // ----------------------------------------
    // masks and modes
    // ----------------------------------------
    mask_retain_a: assert property ($changed(maskShadow) |-> $past(regWr) && $past(regAddr) == 8'h00 || $past(rst) || $past(rst, 2))
        else $error("mask changed without a control write");
    low_gate_a: assert property (subStart && subSource_r == 2'h0 |-> $past(maskShadow[0]) && $past(counterMode) >= 3'h2)
        else $error("low preset start while masked or in mode 0 or 1");
    high_gate_a: assert property (subStart && subSource_r == 2'h1 |-> $past(maskShadow[1]))
        else $error("high preset start while masked");
    under_gate_a: assert property (subStart && subSource_r == 2'h2 |-> $past(maskShadow[2]) && $past(counterMode) >= 3'h2)
        else $error("underflow start while masked or in mode 0 or 1");
endmodule

bind fpci_top fpci_top_monitor fpci_top_monitor_i (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWr(regWr), .counterMode(counterMode), .subDone(subDone), .subStart(subStart),
    .subSource_r(subSource_r), .interruptExecuting(interruptExecuting),
    .maskShadow(maskShadow));

// ---- fpci_top_bench.sv ----
// self-checking bench for the counter event and interrupt flag block
// assumes the checker is bound in from its own file; mode 2 until the last scenario
`timescale 1ns/1ps

module fpci_top_bench;
    reg clk;
    reg rst;
    reg [7:0] regAddr;
    reg [31:0] regWdata;
    reg regWr;
    reg regRd;
    wire [31:0] regRdata_r;
    reg signed [31:0] runningCount;
    reg [2:0] counterMode;
    reg overflowEvent;
    reg executingMode;
    reg subDone;
    wire subStart;
    wire [1:0] subSource_r;
    wire interruptExecuting;
    reg [2:0] retainedMasks;
    wire [2:0] maskShadow;
    integer bad_count;
    integer check_count;

    fpci_top fpci_top_i (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r), .runningCount(runningCount),
        .counterMode(counterMode), .overflowEvent(overflowEvent),
        .executingMode(executingMode), .subDone(subDone), .subStart(subStart),
        .subSource_r(subSource_r), .interruptExecuting(interruptExecuting),
        .retainedMasks(retainedMasks), .maskShadow(maskShadow));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task chk(input [31:0] seen, input [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %0s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task rd(input [7:0] a, input [31:0] exp, input string what);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata_r, exp, what);
    endtask

    task setCount(input [31:0] v);
        @(posedge clk);
        runningCount <= v;
        #1;
    endtask

    task pulseDone();
        @(posedge clk);
        subDone <= 1'b1;
        @(posedge clk);
        subDone <= 1'b0;
        #1;
    endtask

    task waitStart(input [1:0] src);
        integer n;
        n = 0;
        while (subStart !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(subStart, 1'b1, "start pulse");
        chk(subSource_r, src, "start source");
    endtask

    // nothing may start while a source is masked or disabled
    task blocked(input [31:0] ctl, input [31:0] cnt, input [31:0] stat);
        reg seen;
        seen = 1'b0;
        wr(8'h00, ctl);
        setCount(cnt);
        repeat (6) begin
            @(posedge clk);
            #1;
            seen = seen | interruptExecuting | subStart;
        end
        chk(seen, 1'b0, "masked start");
        rd(8'h04, stat, "status after masked event");
        setCount(32'h0000_0032);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset();
        rd(8'h04, 32'h0000_0040, "status at reset");
        rd(8'h00, 32'h0000_000A, "retained masks");
        rd(8'h14, 32'h0000_0000, "unmapped read");
        wr(8'h00, 32'h0000_001F);
        rd(8'h00, 32'h0000_001F, "control write");
        chk(maskShadow, 3'h7, "mask shadow");
    endtask

    task t_high();
        wr(8'h08, 32'h0000_000A);
        wr(8'h0C, 32'h0000_0064);
        wr(8'h10, 32'hFFFF_FFCE);
        setCount(32'h0000_0064);
        waitStart(2'h1);
        rd(8'h04, 32'h0000_0061, "high cause and reached");
        pulseDone();
        @(posedge clk);
        #1;
        chk(interruptExecuting, 1'b0, "executing cleared");
        setCount(32'h0000_0032);
    endtask

    task t_masks();
        blocked(32'h0000_001D, 32'h0000_0005, 32'h0000_0030);
        blocked(32'h0000_001B, 32'h0000_0064, 32'h0000_0060);
        blocked(32'h0000_001E, 32'h0000_0064, 32'h0000_0060);
        blocked(32'h0000_0015, 32'hFFFF_FFC4, 32'h0000_00B0);
        wr(8'h04, 32'h0000_0000);
        rd(8'h04, 32'h0000_0000, "software clear");
        wr(8'h00, 32'h0000_001F);
    endtask

    // one active and two waiting, the fourth is dropped
    task t_queue();
        setCount(32'h0000_0064);
        waitStart(2'h1);
        setCount(32'h0000_0005);
        setCount(32'hFFFF_FFC4);
        @(posedge clk);
        overflowEvent <= 1'b1;
        @(posedge clk);
        overflowEvent <= 1'b0;
        rd(8'h04, 32'h0000_00B7, "queue full and lost");
        pulseDone();
        waitStart(2'h0);
        pulseDone();
        waitStart(2'h2);
        rd(8'h04, 32'h0000_0195, "underflow cause only");
        pulseDone();
        @(posedge clk);
        #1;
        chk(interruptExecuting, 1'b0, "overflow was lost");
        wr(8'h00, 32'h0000_001E);
        @(posedge clk);
        executingMode <= 1'b0;
        repeat (3) @(posedge clk);
        executingMode <= 1'b1;
        rd(8'h04, 32'h0000_0094, "run entry clears cause");
        wr(8'h04, 32'h0000_0000);
        rd(8'h04, 32'h0000_0010, "lost cleared by software");
    endtask

    // overflow behind its own mask, then mode 0 where high runs and low and underflow are blocked
    task t_mode0();
        wr(8'h00, 32'h0000_000F);
        @(posedge clk);
        overflowEvent <= 1'b1;
        @(posedge clk);
        overflowEvent <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(interruptExecuting, 1'b0, "masked overflow");
        wr(8'h00, 32'h0000_001F);
        @(posedge clk);
        overflowEvent <= 1'b1;
        @(posedge clk);
        overflowEvent <= 1'b0;
        #1;
        waitStart(2'h3);
        pulseDone();
        @(posedge clk);
        counterMode <= 3'h0;
        setCount(32'h0000_0064);
        waitStart(2'h1);
        rd(8'h04, 32'h0000_0021, "mode 0 high cause, no reached");
        pulseDone();
        blocked(32'h0000_001F, 32'hFFFF_FFC4, 32'h0000_00A0);
    endtask

    // ----------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (4000) @(posedge clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        bad_count = 0;
        check_count = 0;
        rst = 1'b1;
        regAddr = 8'h00;
        regWdata = 32'h0000_0000;
        regWr = 1'b0;
        regRd = 1'b0;
        runningCount = 32'h0000_0032;
        counterMode = 3'h2;
        overflowEvent = 1'b0;
        executingMode = 1'b1;
        subDone = 1'b0;
        retainedMasks = 3'h5;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_high();
        t_masks();
        t_queue();
        t_mode0();
        end_of_test();
    end
endmodule
